/* File: rtl/sar_burst_pkg.sv */
// constants, encodings and state layouts of the converter burst sequencer
// assumes an 8-bit special register bus with byte and bit writes, one clock
package sar_burst_pkg;

  // =====================================================================
  // register map
  localparam logic [7:0] CTRL_ADDR   = 8'hE8;
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam int         POWER_BIT   = 7;
  localparam int         BURST_BIT   = 6;
  localparam int         DONE_BIT    = 5;
  localparam int         TRIGGER_BIT = 4;
  localparam int         WINDOW_BIT  = 3;

  // =====================================================================
  // start sources
  localparam logic [2:0] SRC_SOFT   = 3'h0;
  localparam logic [2:0] SRC_TIMER0 = 3'h1;
  localparam logic [2:0] SRC_TIMER2 = 3'h2;
  localparam logic [2:0] SRC_TIMER3 = 3'h3;
  localparam logic [2:0] SRC_STROBE = 3'h4;

  // =====================================================================
  // resolution modes
  localparam logic [1:0] RES_12 = 2'h0;
  localparam logic [1:0] RES_10 = 2'h1;
  localparam logic [1:0] RES_8  = 2'h2;

  localparam logic [6:0] COUNT_ZERO = 7'h00;
  localparam logic [4:0] DELAY_ZERO = 5'h00;

  // repeat count select 0..5 gives 1,4,8,16,32,64; reserved codes act as 1
  function automatic logic [6:0] repeat_count(input logic [2:0] sel);
    case (sel)
      3'h1:    repeat_count = 7'h04;
      3'h2:    repeat_count = 7'h08;
      3'h3:    repeat_count = 7'h10;
      3'h4:    repeat_count = 7'h20;
      3'h5:    repeat_count = 7'h40;
      default: repeat_count = 7'h01;
    endcase
  endfunction : repeat_count

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_POWER_UP,
    ST_CONVERT,
    ST_FINISH
  } seq_state_t;

  typedef struct packed {
    seq_state_t state;
    logic       power_enable;
    logic       burst_enable;
    logic       conversion_done_flag;
    logic       conversion_trigger_bit;
    logic       window_match_flag;
    logic [2:0] start_source_select;
    logic       strobe_prev;
    logic [4:0] delay_cnt;
    logic [6:0] conv_cnt;
    logic [6:0] target;
    logic       adc_power;
    logic       adc_start;
    logic       acc_clear;
    logic [7:0] sfr_rdata;
  } ctrl_state_t;

  typedef struct packed {
    logic [15:0] acc;
  } acc_state_t;

endpackage : sar_burst_pkg

/* File: rtl/sample_accumulator.sv */
// 16-bit running sum of conversion results
// assumes clear and add never matter in the same cycle; clear wins if both
`timescale 1ns/100ps
module sample_accumulator
  import sar_burst_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        clear,
  input  wire logic        add_en,
  input  wire logic [11:0] add_value,
  output logic [15:0]      acc
);

  acc_state_t r;
  acc_state_t next_r;

  always_comb begin
    next_r = r;
    if (clear) begin
      next_r.acc = 16'h0000;
    end else if (add_en) begin
      // 64 x 12-bit can wrap; software picks repeat count to fit
      next_r.acc = r.acc + {4'h0, add_value};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign acc = r.acc;

endmodule : sample_accumulator

/* File: rtl/sar_adc_burst_control.sv */
// sequencer for a successive-approximation converter: triggers, burst, flags
// assumes the analog core answers adc_start with one adc_done pulse and result
`timescale 1ns/100ps
module sar_adc_burst_control
  import sar_burst_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // special register bus
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  bit_addr,
  input  wire logic        bit_wdata,
  input  wire logic        bit_wr,
  output logic [7:0]       sfr_rdata,
  // configuration from neighbouring registers
  input  wire logic [1:0]  resolution_mode,
  input  wire logic [2:0]  repeat_select,
  input  wire logic [4:0]  power_up_delay,
  input  wire logic [15:0] window_upper,
  input  wire logic [15:0] window_lower,
  // start sources
  input  wire logic        timer0_overflow,
  input  wire logic        timer2_overflow,
  input  wire logic        timer3_overflow,
  input  wire logic        external_convert_strobe,
  // analog core
  input  wire logic        adc_done,
  input  wire logic [11:0] adc_result,
  output logic             adc_power,
  output logic             adc_start,
  // status
  output logic [15:0]      accumulator,
  output logic             conversion_done_flag,
  output logic             window_match_flag
);

  ctrl_state_t r;
  ctrl_state_t next_r;
  logic [7:0]  ctrl_byte;
  logic [7:0]  wr_mask;
  logic [7:0]  wr_value;
  logic        start_event;
  logic        soft_start;
  logic        acc_add;
  logic [11:0] scaled_result;
  logic [6:0]  cnt_inc;

  assign ctrl_byte = {r.power_enable, r.burst_enable, r.conversion_done_flag,
                      r.conversion_trigger_bit, r.window_match_flag,
                      r.start_source_select};

  // =====================================================================
  // byte and bit writes merged into one mask
  always_comb begin
    wr_mask  = 8'h00;
    wr_value = 8'h00;
    if (sfr_wr && sfr_addr == CTRL_ADDR) begin
      wr_mask  = 8'hFF;
      wr_value = sfr_wdata;
    end else if (bit_wr && bit_addr[7:3] == CTRL_ADDR[7:3]) begin
      wr_mask  = 8'h01 << bit_addr[2:0];
      wr_value = {8{bit_wdata}} & wr_mask;
    end
  end

  assign soft_start = wr_mask[TRIGGER_BIT] && wr_value[TRIGGER_BIT];

  // =====================================================================
  // start source selection
  always_comb begin
    // timers pulse for one cycle; the strobe is a level, its edge is taken here
    case (r.start_source_select)
      SRC_SOFT:   start_event = soft_start;
      SRC_TIMER0: start_event = timer0_overflow;
      SRC_TIMER2: start_event = timer2_overflow;
      SRC_TIMER3: start_event = timer3_overflow;
      SRC_STROBE: start_event = external_convert_strobe && !r.strobe_prev;
      default:    start_event = 1'b0;
    endcase
  end

  // right-justify to the chosen resolution
  always_comb begin
    case (resolution_mode)
      RES_10:  scaled_result = {2'h0, adc_result[11:2]};
      RES_8:   scaled_result = {4'h0, adc_result[11:4]};
      default: scaled_result = adc_result;
    endcase
  end

  assign acc_add = (r.state == ST_CONVERT) && adc_done;
  assign cnt_inc = r.conv_cnt + 7'h01;

  // =====================================================================
  // sequencer
  always_comb begin
    next_r             = r;
    next_r.strobe_prev = external_convert_strobe;
    next_r.adc_start   = 1'b0;
    next_r.acc_clear   = 1'b0;
    next_r.sfr_rdata   = (sfr_rd && sfr_addr == CTRL_ADDR) ? ctrl_byte : 8'h00;

    // software side of the register; trigger bit belongs to the sequencer
    next_r.power_enable = wr_mask[POWER_BIT] ? wr_value[POWER_BIT] : r.power_enable;
    next_r.burst_enable = wr_mask[BURST_BIT] ? wr_value[BURST_BIT] : r.burst_enable;
    if (wr_mask[DONE_BIT]) begin
      next_r.conversion_done_flag = wr_value[DONE_BIT];
    end
    if (wr_mask[WINDOW_BIT]) begin
      next_r.window_match_flag = wr_value[WINDOW_BIT];
    end
    if (wr_mask[2:0] == 3'h7) begin
      next_r.start_source_select = wr_value[2:0];
    end

    case (r.state)
      ST_IDLE: begin
        // idle power state is the enable bit in both modes, so a switch
        // from single to burst with enable clear still shuts down
        next_r.adc_power = r.power_enable;
        // single mode refuses starts while the converter is disabled
        if (start_event && (r.burst_enable || r.power_enable)) begin
          next_r.conversion_trigger_bit = 1'b1;
          // power stays up for the whole sequence
          next_r.adc_power = 1'b1;
          if (r.burst_enable || r.conv_cnt == COUNT_ZERO) begin
            next_r.conv_cnt  = COUNT_ZERO;
            next_r.acc_clear = 1'b1;
            next_r.target    = repeat_count(repeat_select);
          end
          if (r.adc_power) begin
            next_r.adc_start = 1'b1;
            next_r.state     = ST_CONVERT;
          end else begin
            next_r.adc_power = 1'b1;
            next_r.delay_cnt = power_up_delay;
            next_r.state     = ST_POWER_UP;
          end
        end
      end
      ST_POWER_UP: begin
        // count down to zero, then launch the first conversion
        if (r.delay_cnt == DELAY_ZERO) begin
          next_r.adc_start = 1'b1;
          next_r.state     = ST_CONVERT;
        end else begin
          next_r.delay_cnt = r.delay_cnt - 5'h01;
        end
      end
      ST_CONVERT: begin
        if (adc_done) begin
          next_r.conv_cnt = cnt_inc;
          if (cnt_inc >= r.target) begin
            next_r.state = ST_FINISH;
          end else if (r.burst_enable) begin
            // burst keeps going without a new start, no idle cycle between;
            // limitation: paced by sys_clk, not by a private fast clock
            next_r.adc_start = 1'b1;
          end else begin
            // single mode waits for the next start event
            next_r.conversion_trigger_bit = 1'b0;
            next_r.state                  = ST_IDLE;
          end
        end
      end
      ST_FINISH: begin
        // accumulator already holds the final sum in this cycle
        next_r.conversion_done_flag = 1'b1;
        if (accumulator >= window_lower && accumulator <= window_upper) begin
          next_r.window_match_flag = 1'b1;
        end
        next_r.conv_cnt               = COUNT_ZERO;
        next_r.conversion_trigger_bit = 1'b0;
        if (r.burst_enable && !r.power_enable) begin
          next_r.adc_power = 1'b0;
        end
        next_r.state = ST_IDLE;
      end
      default: begin
        next_r.state = ST_IDLE;
      end
    endcase
  end

  // =====================================================================
  // state register
  // register fields reset from one constant so the reset byte stays in one place
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      r                        <= '0;
      r.state                  <= ST_IDLE;
      r.power_enable           <= CTRL_RESET[POWER_BIT];
      r.burst_enable           <= CTRL_RESET[BURST_BIT];
      r.conversion_done_flag   <= CTRL_RESET[DONE_BIT];
      r.conversion_trigger_bit <= CTRL_RESET[TRIGGER_BIT];
      r.window_match_flag      <= CTRL_RESET[WINDOW_BIT];
      r.start_source_select    <= CTRL_RESET[2:0];
    end else begin
      r <= next_r;
    end
  end

  // =====================================================================
  // result sum
  sample_accumulator u_acc (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .clear     (r.acc_clear),
    .add_en    (acc_add),
    .add_value (scaled_result),
    .acc       (accumulator)
  );

  // =====================================================================
  // outputs, all straight from flip-flops
  assign sfr_rdata            = r.sfr_rdata;
  assign adc_power            = r.adc_power;
  assign adc_start            = r.adc_start;
  assign conversion_done_flag = r.conversion_done_flag;
  assign window_match_flag    = r.window_match_flag;

endmodule : sar_adc_burst_control

/* File: sim/sar_burst_checker_asserts.sv */
// port assertions for the converter sequencer
// assumes it is bound into sar_adc_burst_control, one clock
`timescale 1ns/100ps
module sar_burst_checker
  import sar_burst_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic [7:0]  sfr_addr,
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic        bit_wr,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        adc_done,
  input wire logic        adc_power,
  input wire logic        adc_start,
  input wire logic [15:0] accumulator,
  input wire logic        conversion_done_flag,
  input wire logic        window_match_flag
);
  // ====
  // properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence sw_touch;
    $past(sfr_wr) || $past(bit_wr);
  endsequence
  sequence wake;
    $rose(adc_power);
  endsequence
  rd_other_zero_a: assert property (sfr_rd && sfr_addr != CTRL_ADDR |=> sfr_rdata == 8'h00)
    else $error("read of other address not zero");
  rd_flags_a: assert property (sfr_rd && sfr_addr == CTRL_ADDR |=>
    sfr_rdata[DONE_BIT] == $past(conversion_done_flag)
    && sfr_rdata[WINDOW_BIT] == $past(window_match_flag)) else $error("flag bits misread");
  start_pulse_a: assert property (adc_start |=> !adc_start) else $error("start not a pulse");
  start_powered_a: assert property (adc_start |-> adc_power) else $error("start unpowered");
  wake_wait_a: assert property (wake |-> !adc_start) else $error("no power-up wait");
  done_cause_a: assert property ($rose(conversion_done_flag) |->
    $past(adc_done, 2) or sw_touch) else $error("done flag without conversion");
  window_cause_a: assert property ($rose(window_match_flag) |->
    $past(adc_done, 2) or sw_touch) else $error("window flag without conversion");
  flag_hold_a: assert property ($fell(conversion_done_flag) && $past(rst_b) |->
    sw_touch) else $error("done flag cleared by hardware");
  acc_cause_a: assert property ($changed(accumulator) && $past(rst_b) |->
    accumulator == 16'h0000 || $past(adc_done)) else $error("accumulator moved alone");
endmodule : sar_burst_checker

bind sar_adc_burst_control sar_burst_checker sar_burst_checker_inst (.*);

/* File: sim/adc_core_model.sv */
// analog core stand-in: one done pulse with a result per start
// assumes starts come only while powered; slow stretches conversion
`timescale 1ns/100ps
module adc_core_model #(
  parameter logic [11:0] RESULT = 12'h123
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        slow,
  input  wire logic        adc_power,
  input  wire logic        adc_start,
  output logic             adc_done,
  output logic [11:0]      adc_result
);
  logic [3:0] wait_cnt;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_cnt <= 4'h0;
      adc_done <= 1'b0;
      adc_result <= 12'h000;
    end else begin
      adc_done <= (wait_cnt == 4'h1);
      // scrambled off the done cycle so a late capture shows up
      adc_result <= (wait_cnt == 4'h1) ? RESULT : ~adc_result;
      if (adc_start && adc_power) wait_cnt <= slow ? 4'h6 : 4'h1;
      else if (wait_cnt != 4'h0) wait_cnt <= wait_cnt - 4'h1;
    end
  end
endmodule : adc_core_model

/* File: sim/testbench.sv */
// self-checking bench for the converter sequencer
// assumes the core stand-in and the bound checker are compiled first
`timescale 1ns/100ps
module testbench;
  import sar_burst_pkg::*;
  localparam logic [11:0] RESULT = 12'h123;
  logic        sys_clk, rst_b, sfr_wr, sfr_rd, bit_wdata, bit_wr, slow, adc_done;
  logic [7:0]  sfr_addr, sfr_wdata, bit_addr, sfr_rdata;
  logic [1:0]  resolution_mode;
  logic [2:0]  repeat_select;
  logic [4:0]  power_up_delay;
  logic [15:0] window_upper, window_lower, accumulator;
  logic        timer0_overflow, timer2_overflow, timer3_overflow, external_convert_strobe;
  logic        adc_power, adc_start, conversion_done_flag, window_match_flag;
  logic [11:0] adc_result;
  int          n_errors, checks_done, cycles;

  sar_adc_burst_control sar_adc_burst_control_inst (.*);
  adc_core_model #(.RESULT(RESULT)) adc_core_model_inst (.*);

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end

  // ====
  // bus and compare helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    {sfr_addr, sfr_wdata, sfr_wr} <= {a, d, 1'b1};
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
  endtask : wr
  task automatic bw(input logic [7:0] a, input logic v);
    @(posedge sys_clk);
    {bit_addr, bit_wdata, bit_wr} <= {a, v, 1'b1};
    @(posedge sys_clk);
    bit_wr <= 1'b0;
  endtask : bw
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    {sfr_addr, sfr_rd} <= {a, 1'b1};
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
    @(negedge sys_clk);
    check(16'(sfr_rdata), 16'(exp));
  endtask : rd
  task automatic pulse(input logic [2:0] s);
    @(posedge sys_clk);
    {timer0_overflow, timer2_overflow, timer3_overflow, external_convert_strobe}
      <= {s == 3'h1, s == 3'h2, s == 3'h3, s == 3'h4};
    @(posedge sys_clk);
    {timer0_overflow, timer2_overflow, timer3_overflow, external_convert_strobe} <= 4'h0;
  endtask : pulse
  // start, count starts until done, judge, clear flags
  task automatic run(input logic [7:0] c, input logic [6:0] n, input int sh, input int first);
    int          k;
    int          cnt;
    logic [15:0] sum;
    k = 0;
    cnt = 0;
    sum = 16'(n) * 16'(RESULT >> sh);
    if (c[2:0] == SRC_SOFT) wr(CTRL_ADDR, c | 8'h10);
    else begin
      wr(CTRL_ADDR, c);
      pulse(c[2:0]);
    end
    while (conversion_done_flag !== 1'b1 && k < 2000) begin
      @(negedge sys_clk);
      k++;
      if (adc_start === 1'b1 && cnt++ == 0) check(16'(k), 16'(first));
    end
    check(16'(cnt), c[6] ? 16'(n) : 16'h0001);
    check(accumulator, sum);
    check({15'h0, window_match_flag}, {15'h0, sum >= 16'h0100 && sum <= 16'h0500});
    check({15'h0, adc_power}, {15'h0, c[7]});
    wr(CTRL_ADDR, c & 8'hC7);
  endtask : run

  // ====
  // scenarios
  task automatic reg_access;
    rd(CTRL_ADDR, CTRL_RESET);
    wr(8'hE0, 8'hFF);
    rd(8'hE0, 8'h00);
    bw(8'hEF, 1'b1);
    bw(8'hEA, 1'b1);
    rd(CTRL_ADDR, 8'h80);
  endtask : reg_access
  task automatic single_modes;
    for (int m = 0; m < 3; m++) begin
      @(posedge sys_clk);
      resolution_mode <= 2'(m);
      slow <= m[0];
      run(8'h80, 7'h01, 2 * m, 1);
    end
  endtask : single_modes
  task automatic single_repeat;
    @(posedge sys_clk);
    repeat_select <= 3'h1;
    // code 3 acts as full resolution from here on
    resolution_mode <= 2'h3;
    repeat (3) begin
      wr(CTRL_ADDR, 8'h90);
      repeat (12) @(negedge sys_clk);
      check({15'h0, conversion_done_flag}, 16'h0000);
    end
    run(8'h80, 7'h04, 0, 1);
  endtask : single_repeat
  task automatic burst_counts;
    wr(CTRL_ADDR, 8'h40);
    repeat (2) @(negedge sys_clk);
    check({15'h0, adc_power}, 16'h0000);
    for (int s = 0; s < 8; s++) begin
      @(posedge sys_clk);
      repeat_select <= 3'(s);
      slow <= s[0];
      run(8'h40, (s == 0 || s > 5) ? 7'h01 : 7'h02 << s, 0, 5);
    end
  endtask : burst_counts
  task automatic burst_sources;
    int cnt;
    cnt = 0;
    @(posedge sys_clk);
    repeat_select <= 3'h1;
    wr(CTRL_ADDR, 8'hC0);
    for (int s = 1; s < 5; s++) run(8'hC0 | 8'(s), 7'h04, 0, 1);
    // reserved source: neither trigger bit nor timer may start
    wr(CTRL_ADDR, 8'hD5);
    pulse(3'h1);
    repeat (20) begin
      @(negedge sys_clk);
      cnt += int'(adc_start === 1'b1);
    end
    check(16'(cnt), 16'h0000);
  endtask : burst_sources

  task automatic finish_test;
    if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  initial begin
    {rst_b, sfr_wr, sfr_rd, bit_wdata, bit_wr, slow, sfr_addr, sfr_wdata, bit_addr} = '0;
    {resolution_mode, repeat_select, timer0_overflow, timer2_overflow} = '0;
    {timer3_overflow, external_convert_strobe} = '0;
    {n_errors, checks_done, cycles} = '0;
    power_up_delay = 5'h03;
    window_lower = 16'h0100;
    window_upper = 16'h0500;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    reg_access();
    single_modes();
    single_repeat();
    burst_counts();
    burst_sources();
    finish_test();
  end
endmodule : testbench
